// *** shared/spi_queue_pkg.sv ***
// Purpose: Constants and types for the queued serial engine and its shared memory.
// Assumes: Shared memory is addressed in bytes, even byte holds the high half of a word.
// Notes: Control fields arrive as plain ports from the host module.
// Functional notes
// - One 80-byte memory shared by CPU port and engine, with arbitration.
// - With engine enabled, each part of a CPU access takes one to three wait states.
// - Byte, word and long CPU access; aligned word is atomic, engine locked out.
// - Long or misaligned word access splits in two; engine may run between.
// - Memory holds receive words, transmit words and command bytes.
// - Enabled engine runs the queue alone, then sets finished flag and waits.
// - Received words are stored right-justified, last bit at bit 0.
// - Receive bits above the transfer length are written as zero.
// - Engine only copies transmit words, never writes them.
// - Command bytes read only in master mode, never modified by engine.
// - Sixteen command bytes, each with select pattern and control options.
// - Entries 0 to 15 run from start pointer through end pointer.
// - Four select bits drive four pins directly; several may be active.
// - Port data sets select pins when disabled, unassigned or between transfers with hold clear.
// - Pins take command pattern; with hold clear, port data returns after.
// - Hold set with same next pattern keeps pins steady across transfers.
// - Hold set with new pattern keeps old pattern until switching directly.
// - Bit-count select 1 uses global bit count, 0 gives eight bits.
// - Delay-after-transfer bit waits global delay after that transfer.
// - Clock-delay bit uses global select delay, else half a serial clock.
// - One index selects command byte, transmit word and receive word.
// - After each command compare completed and end pointer; match sets flag, stops.
package spi_queue_pkg;
  localparam logic [6:0] TX_BASE = 7'h20;
  localparam logic [6:0] CMD_BASE = 7'h40;
  localparam logic [6:0] RAM_END = 7'h50;
  localparam int CMD_HOLD = 7;
  localparam int CMD_GBITS = 6;
  localparam int CMD_DT = 5;
  localparam int CMD_SELECT_TO_CLOCK_DELAY_ENABLE = 4;
  localparam logic [4:0] DEFAULT_BITS = 5'h08;
  localparam logic [4:0] FULL_BITS = 5'h10;
  localparam logic [13:0] DELAY_STEP = 14'h0020;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  typedef enum logic [7:0] {
    E_IDLE = 8'h01, E_FETCH = 8'h02, E_HALF = 8'h04, E_SELDLY = 8'h08,
    E_SHIFT = 8'h10, E_WBACK = 8'h20, E_AFTDLY = 8'h40, E_DONE = 8'h80
  } eng_state_t;
  typedef enum logic [2:0] {C_IDLE = 3'h1, C_WAIT = 3'h2, C_ACC = 3'h4} cpu_state_t;
endpackage

// *** hw/spi_shifter.sv ***
// Purpose: Serial shifter timed by the sampled link clock.
// Assumes: Data leaves on falling edges and is sampled on rising edges.
// Notes: Link clock and input data pass two flip-flops before use.
`timescale 1ns/1ps
module spi_shifter (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_miso,
  input wire logic start,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx_word,
  output logic link_edge,
  output logic done,
  output logic [15:0] rx_word,
  output logic sck,
  output logic mosi
);
  typedef struct packed {
    logic [1:0] c1;
    logic [1:0] c2;
    logic c3;
    logic busy;
    logic seen_rise;
    logic [4:0] cnt;
    logic [15:0] tx;
    logic [15:0] rx;
    logic sck;
    logic mosi;
    logic done;
  } sh_t;
  sh_t q;
  sh_t n;
  logic rise;
  logic fall;

  always_comb begin
    n = q;
    n.c1 = {link_clk, link_miso};
    n.c2 = q.c1;
    n.c3 = q.c2[1];
    n.done = 1'b0;
    rise = q.c2[1] & ~q.c3;
    fall = ~q.c2[1] & q.c3;
    link_edge = rise | fall;
    if (start) begin
      n.busy = 1'b1;
      n.seen_rise = 1'b0;
      n.cnt = nbits;
      n.tx = tx_word;
      n.rx = 16'h0000;
      n.mosi = tx_word[4'(nbits - 5'h01)];
    end else if (q.busy && rise) begin
      n.sck = 1'b1;
      n.seen_rise = 1'b1;
      n.rx = {q.rx[14:0], q.c2[0]};
      n.cnt = q.cnt - 5'h01;
    end else if (q.busy && fall && q.seen_rise) begin
      n.sck = 1'b0;
      if (q.cnt == 5'h00) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.mosi = q.tx[4'(q.cnt - 5'h01)];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
  assign rx_word = q.rx;
  assign sck = q.sck;
  assign mosi = q.mosi;
endmodule

// *** hw/spi_queue_core.sv ***
// Purpose: Shared queue memory, CPU port and queue engine of the serial master.
// Assumes: Control fields are steady CPU-domain levels; long accesses are word aligned.
// Notes: Slave mode, halt and wraparound are outside this block.
`timescale 1ns/1ps
module spi_queue_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_size,
  input wire logic [6:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  input wire logic engine_enable,
  input wire logic master_select,
  input wire logic [3:0] queue_start_pointer,
  input wire logic [3:0] queue_end_pointer,
  input wire logic [3:0] global_bit_count,
  input wire logic [6:0] select_to_clock_delay_length,
  input wire logic [7:0] after_transfer_delay_length,
  input wire logic [3:0] port_data_register,
  input wire logic [3:0] pin_assignment_register,
  input wire logic [3:0] pin_direction_register,
  input wire logic finished_clear,
  output logic [3:0] completed_entry_pointer,
  output logic queue_finished_flag,
  output logic [3:0] peripheral_select_pattern,
  output logic [3:0] peripheral_select_oe,
  input wire logic link_clk,
  input wire logic link_miso,
  output logic link_sck,
  output logic link_mosi
);
  typedef struct packed {
    spi_queue_pkg::eng_state_t st;
    logic [3:0] idx;
    logic [7:0] cmd;
    logic [15:0] txw;
    logic [4:0] nbits;
    logic [13:0] dcnt;
    logic [3:0] cpt;
    logic fin;
    logic cs_act;
    logic [3:0] cs_pat;
    logic [3:0] pcs;
    logic [3:0] pcs_oe;
    logic start;
    spi_queue_pkg::cpu_state_t cst;
    logic part2;
    logic [6:0] addr;
    logic [1:0] size;
    logic we;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic [15:0][15:0] rx;
    logic [15:0][15:0] tx;
    logic [15:0][7:0] cmdr;
  } state_t;

  state_t q;
  state_t n;
  logic sh_edge;
  logic sh_done;
  logic [15:0] sh_rx;
  logic eng_mem;
  logic two_part;
  logic pn2;
  logic [6:0] pa;
  logic [6:0] ba;
  logic [7:0] bv;
  logic [15:0] pd;
  logic [15:0] rv;
  logic advance;

  // One byte of the shared memory; unmapped bytes read as zero.
  function automatic logic [7:0] rd_byte(input state_t s, input logic [6:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a < spi_queue_pkg::TX_BASE) begin
      w = s.rx[a[4:1]];
    end else if (a < spi_queue_pkg::CMD_BASE) begin
      w = s.tx[a[4:1]];
    end
    if (a >= spi_queue_pkg::CMD_BASE && a < spi_queue_pkg::RAM_END) begin
      rd_byte = s.cmdr[a[3:0]];
    end else begin
      rd_byte = a[0] ? w[7:0] : w[15:8];
    end
  endfunction

  // Clears every bit at or above the transfer length.
  function automatic logic [15:0] len_mask(input logic [15:0] w, input logic [4:0] nb);
    logic [16:0] m;
    m = (17'h00001 << nb) - 17'h00001;
    len_mask = w & m[15:0];
  endfunction

  spi_shifter u_shifter (
    .mclk(mclk),
    .rst_n(rst_n),
    .link_clk(link_clk),
    .link_miso(link_miso),
    .start(q.start),
    .nbits(q.nbits),
    .tx_word(q.txw),
    .link_edge(sh_edge),
    .done(sh_done),
    .rx_word(sh_rx),
    .sck(link_sck),
    .mosi(link_mosi)
  );

  always_comb begin
    n = q;
    n.ack = 1'b0;
    n.start = 1'b0;
    advance = 1'b0;
    ba = 7'h00;
    bv = 8'h00;
    // The engine owns the memory in its fetch and write-back cycles.
    eng_mem = (q.st == spi_queue_pkg::E_FETCH) || (q.st == spi_queue_pkg::E_WBACK);

    // ************************************************************
    // CPU port: one memory cycle per part.
    // ************************************************************
    two_part = (q.size == spi_queue_pkg::SZ_LONG) || (q.size == spi_queue_pkg::SZ_WORD && q.addr[0]);
    if (q.size == spi_queue_pkg::SZ_LONG) begin
      pa = q.part2 ? q.addr + 7'h02 : q.addr;
      pn2 = 1'b1;
      pd = q.part2 ? q.wdata[15:0] : q.wdata[31:16];
    end else if (q.size == spi_queue_pkg::SZ_WORD && !q.addr[0]) begin
      pa = q.addr;
      pn2 = 1'b1;
      pd = q.wdata[15:0];
    end else if (q.size == spi_queue_pkg::SZ_WORD) begin
      pa = q.part2 ? q.addr + 7'h01 : q.addr;
      pn2 = 1'b0;
      pd = {8'h00, q.part2 ? q.wdata[7:0] : q.wdata[15:8]};
    end else begin
      pa = q.addr;
      pn2 = 1'b0;
      pd = {8'h00, q.wdata[7:0]};
    end
    rv = pn2 ? {rd_byte(q, pa), rd_byte(q, pa + 7'h01)} : {8'h00, rd_byte(q, pa)};

    case (q.cst)
      spi_queue_pkg::C_IDLE: begin
        if (cpu_req && !q.ack) begin
          n.addr = cpu_addr;
          n.size = cpu_size;
          n.we = cpu_wr;
          n.wdata = cpu_wdata;
          n.part2 = 1'b0;
          n.cst = engine_enable ? spi_queue_pkg::C_WAIT : spi_queue_pkg::C_ACC;
        end
      end
      spi_queue_pkg::C_WAIT: begin
        n.cst = spi_queue_pkg::C_ACC;
      end
      spi_queue_pkg::C_ACC: begin
        if (!eng_mem) begin
          if (q.we) begin
            for (int k = 0; k < 2; k++) begin
              if (k == 0 || pn2) begin
                ba = pa + 7'(k);
                bv = (pn2 && k == 0) ? pd[15:8] : pd[7:0];
                if (ba < spi_queue_pkg::TX_BASE) begin
                  n.rx[ba[4:1]][{~ba[0], 3'b000} +: 8] = bv;
                end else if (ba < spi_queue_pkg::CMD_BASE) begin
                  n.tx[ba[4:1]][{~ba[0], 3'b000} +: 8] = bv;
                end else if (ba < spi_queue_pkg::RAM_END) begin
                  n.cmdr[ba[3:0]] = bv;
                end
              end
            end
          end else if (two_part && !q.part2) begin
            // The first half waits in the unused write data so the read data stands until ack.
            n.wdata = {16'h0000, rv};
          end else if (!q.part2) begin
            n.rdata = {16'h0000, rv};
          end else if (q.size == spi_queue_pkg::SZ_LONG) begin
            n.rdata = {q.wdata[15:0], rv};
          end else begin
            n.rdata = {16'h0000, q.wdata[7:0], rv[7:0]};
          end
          if (two_part && !q.part2) begin
            n.part2 = 1'b1;
            n.cst = engine_enable ? spi_queue_pkg::C_WAIT : spi_queue_pkg::C_ACC;
          end else begin
            n.ack = 1'b1;
            n.cst = spi_queue_pkg::C_IDLE;
          end
        end
      end
      default: begin
        n.cst = spi_queue_pkg::C_IDLE;
      end
    endcase

    // ************************************************************
    // Queue engine.
    // ************************************************************
    case (q.st)
      spi_queue_pkg::E_IDLE: begin
        if (engine_enable && master_select) begin
          n.idx = queue_start_pointer;
          n.st = spi_queue_pkg::E_FETCH;
        end
      end
      spi_queue_pkg::E_FETCH: begin
        n.cmd = q.cmdr[q.idx];
        n.txw = q.tx[q.idx];
        n.cs_pat = q.cmdr[q.idx][3:0];
        n.cs_act = 1'b1;
        if (q.cmdr[q.idx][spi_queue_pkg::CMD_GBITS]) begin
          n.nbits = (global_bit_count == 4'h0) ? spi_queue_pkg::FULL_BITS : {1'b0, global_bit_count};
        end else begin
          n.nbits = spi_queue_pkg::DEFAULT_BITS;
        end
        if (q.cmdr[q.idx][spi_queue_pkg::CMD_SELECT_TO_CLOCK_DELAY_ENABLE]) begin
          n.dcnt = (select_to_clock_delay_length == 7'h00) ? 14'h0001 : {7'h00, select_to_clock_delay_length};
          n.st = spi_queue_pkg::E_SELDLY;
        end else begin
          n.st = spi_queue_pkg::E_HALF;
        end
      end
      spi_queue_pkg::E_HALF: begin
        if (sh_edge) begin
          n.start = 1'b1;
          n.st = spi_queue_pkg::E_SHIFT;
        end
      end
      spi_queue_pkg::E_SELDLY: begin
        n.dcnt = q.dcnt - 14'h0001;
        if (q.dcnt == 14'h0001) begin
          n.start = 1'b1;
          n.st = spi_queue_pkg::E_SHIFT;
        end
      end
      spi_queue_pkg::E_SHIFT: begin
        if (sh_done) begin
          n.cs_act = q.cmd[spi_queue_pkg::CMD_HOLD];
          n.st = spi_queue_pkg::E_WBACK;
        end
      end
      spi_queue_pkg::E_WBACK: begin
        n.rx[q.idx] = len_mask(sh_rx, q.nbits);
        n.cpt = q.idx;
        if (q.cmd[spi_queue_pkg::CMD_DT]) begin
          n.dcnt = {6'h00, after_transfer_delay_length} * spi_queue_pkg::DELAY_STEP;
          if (after_transfer_delay_length == 8'h00) begin
            n.dcnt = 14'h2000;
          end
          n.st = spi_queue_pkg::E_AFTDLY;
        end else begin
          advance = 1'b1;
        end
      end
      spi_queue_pkg::E_AFTDLY: begin
        n.dcnt = q.dcnt - 14'h0001;
        if (q.dcnt == 14'h0001) begin
          advance = 1'b1;
        end
      end
      spi_queue_pkg::E_DONE: begin
        if (!engine_enable) begin
          n.st = spi_queue_pkg::E_IDLE;
        end
      end
      default: begin
        n.st = spi_queue_pkg::E_IDLE;
      end
    endcase

    if (advance) begin
      if (n.cpt == queue_end_pointer) begin
        n.st = spi_queue_pkg::E_DONE;
      end else begin
        n.idx = q.idx + 4'h1;
        n.st = spi_queue_pkg::E_FETCH;
      end
    end

    // A finish in the same cycle as a clear keeps the flag set.
    n.fin = (q.fin & ~finished_clear) | (advance && n.cpt == queue_end_pointer);

    if (!engine_enable) begin
      n.st = spi_queue_pkg::E_IDLE;
      n.cs_act = 1'b0;
      n.start = 1'b0;
    end

    // ************************************************************
    // Select pins.
    // ************************************************************
    for (int i = 0; i < 4; i++) begin
      if (engine_enable && q.cs_act && pin_assignment_register[i]) begin
        n.pcs[i] = q.cs_pat[i];
      end else begin
        n.pcs[i] = port_data_register[i];
      end
    end
    n.pcs_oe = pin_direction_register;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= spi_queue_pkg::E_IDLE;
      q.cst <= spi_queue_pkg::C_IDLE;
      q.cpt <= spi_queue_pkg::PTR_RESET;
    end else begin
      q <= n;
    end
  end

  assign cpu_ack = q.ack;
  assign cpu_rdata = q.rdata;
  assign completed_entry_pointer = q.cpt;
  assign queue_finished_flag = q.fin;
  assign peripheral_select_pattern = q.pcs;
  assign peripheral_select_oe = q.pcs_oe;
endmodule

// *** sim/spi_queue_core_sva.sv ***
// Purpose: Port-level checks of the queue memory port, queue engine and select pins.
// Assumes: Bench requests one access at a time and keeps control inputs steady while running.
// Notes: Bound to spi_queue_core below.
`timescale 1ns/1ps
module spi_queue_core_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire logic [1:0] cpu_size,
  input wire logic [6:0] cpu_addr,
  input wire logic cpu_ack,
  input wire logic [31:0] cpu_rdata,
  input wire logic engine_enable,
  input wire logic [3:0] queue_end_pointer,
  input wire logic [3:0] port_data_register,
  input wire logic [3:0] pin_direction_register,
  input wire logic finished_clear,
  input wire logic [3:0] completed_entry_pointer,
  input wire logic queue_finished_flag,
  input wire logic [3:0] peripheral_select_pattern,
  input wire logic [3:0] peripheral_select_oe,
  input wire logic link_sck
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_one_part;
    $rose(cpu_req) && (cpu_size == spi_queue_pkg::SZ_BYTE || (cpu_size == spi_queue_pkg::SZ_WORD && !cpu_addr[0]));
  endsequence
  sequence s_two_parts;
    $rose(cpu_req) && (cpu_size == spi_queue_pkg::SZ_LONG || (cpu_size == spi_queue_pkg::SZ_WORD && cpu_addr[0]));
  endsequence
  sequence s_quiet_two;
    !cpu_ack ##1 !cpu_ack;
  endsequence
  a_ack_direct: assert property (s_one_part ##0 !engine_enable |=> !cpu_ack ##[1:2] cpu_ack)
    else $error("single access answered at the wrong time");
  a_ack_split: assert property (s_two_parts ##0 !engine_enable |=> s_quiet_two ##[1:2] cpu_ack)
    else $error("split access answered at the wrong time");
  a_ack_waits: assert property (s_one_part ##0 engine_enable |=> s_quiet_two ##[1:6] cpu_ack)
    else $error("wait states out of range");
  a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
    else $error("ack longer than one cycle");
  a_rdata_stands: assert property (!cpu_ack |-> $stable(cpu_rdata))
    else $error("read data moved without ack");
  a_flag_sticky: assert property (queue_finished_flag && !finished_clear |=> queue_finished_flag)
    else $error("finished flag dropped");
  a_flag_at_end: assert property ($rose(queue_finished_flag) |-> completed_entry_pointer == queue_end_pointer)
    else $error("finished flag before end entry");
  a_pins_idle: assert property (!engine_enable [*3] |-> peripheral_select_pattern == $past(port_data_register))
    else $error("select pins not from port data");
  a_oe_follows: assert property (1'b1 |=> peripheral_select_oe == $past(pin_direction_register))
    else $error("pin enable not from direction");
  a_sck_quiet: assert property (!engine_enable [*4] |-> !link_sck)
    else $error("serial clock runs while disabled");
  a_pins_steady: assert property (link_sck |-> $stable(peripheral_select_pattern))
    else $error("select pins moved while clocking");
  a_ptr_frozen: assert property (!engine_enable ##1 !engine_enable |-> $stable(completed_entry_pointer))
    else $error("completed pointer moved while idle");
endmodule
bind spi_queue_core spi_queue_core_sva chk (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_size(cpu_size),
  .cpu_addr(cpu_addr), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .engine_enable(engine_enable),
  .queue_end_pointer(queue_end_pointer), .port_data_register(port_data_register),
  .pin_direction_register(pin_direction_register), .finished_clear(finished_clear),
  .completed_entry_pointer(completed_entry_pointer), .queue_finished_flag(queue_finished_flag),
  .peripheral_select_pattern(peripheral_select_pattern), .peripheral_select_oe(peripheral_select_oe),
  .link_sck(link_sck));

// *** sim/spi_peripheral_model.sv ***
// Purpose: Serial peripheral answering the engine, one reply word per select pattern.
// Assumes: Selected whenever the pins differ from their idle level.
// Notes: Reply is shifted out most significant bit first.
`timescale 1ns/1ps
module spi_peripheral_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic [3:0] sel,
  input wire logic [3:0] idle_sel,
  output logic miso,
  output logic [15:0] rx_word
);
  // ********************************
  // Shifter
  // ********************************
  logic [15:0] sr_q = 16'h0000;
  logic selected;
  initial rx_word = 16'h0000;
  assign selected = (sel != idle_sel);
  // A released data line shows the inverse of the reply register's top bit, not the bit itself.
  assign miso = selected ? sr_q[15] : ~sr_q[15];
  always @(sel) begin
    sr_q <= {4{sel}} ^ 16'h3c96;
    if (sel != idle_sel) rx_word <= 16'h0000;
  end
  always @(posedge sck) if (selected) rx_word <= {rx_word[14:0], mosi};
  always @(negedge sck) if (selected) sr_q <= {sr_q[14:0], ~sr_q[15]};
endmodule

// *** sim/queued_spi_ram_and_command_queue_test.sv ***
// Purpose: Self-checking bench for the shared queue memory and queue engine.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Two queues run, one switching patterns, one holding a pattern.
`timescale 1ns/1ps
module queued_spi_ram_and_command_queue_test;
  logic mclk = 1'b0, rst_n = 1'b0, cpu_req = 1'b0, cpu_wr = 1'b0, cpu_ack, engine_enable = 1'b0;
  logic master_select = 1'b0, finished_clear = 1'b0, queue_finished_flag, link_clk = 1'b0, link_miso, link_sck;
  logic link_mosi;
  logic [1:0] cpu_size = 2'h0;
  logic [6:0] cpu_addr = 7'h00, select_to_clock_delay_length = 7'h00;
  logic [31:0] cpu_wdata = 32'h0, cpu_rdata;
  logic [3:0] queue_start_pointer = 4'h0, queue_end_pointer = 4'h0, global_bit_count = 4'h0;
  logic [3:0] port_data_register = 4'h0, pin_assignment_register = 4'h0, pin_direction_register = 4'h0;
  logic [3:0] completed_entry_pointer, peripheral_select_pattern, peripheral_select_oe;
  logic [7:0] after_transfer_delay_length = 8'h00;
  logic [15:0] rx_word;
  int fails = 0, num_checks = 0;
  spi_queue_core uut (.mclk, .rst_n, .cpu_req, .cpu_wr, .cpu_size, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_rdata,
    .engine_enable, .master_select, .queue_start_pointer, .queue_end_pointer, .global_bit_count,
    .select_to_clock_delay_length, .after_transfer_delay_length, .port_data_register, .pin_assignment_register,
    .pin_direction_register, .finished_clear, .completed_entry_pointer, .queue_finished_flag,
    .peripheral_select_pattern, .peripheral_select_oe, .link_clk, .link_miso, .link_sck, .link_mosi);
  spi_peripheral_model peer (.sck(link_sck), .mosi(link_mosi), .sel(peripheral_select_pattern),
    .idle_sel(port_data_register), .miso(link_miso), .rx_word(rx_word));
  // ********************************
  // Clocks and tasks
  // ********************************
  always #4 mclk = ~mclk;
  // The link clock stands still while the engine is disabled.
  always #40 link_clk = engine_enable ? ~link_clk : 1'b0;
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] sz, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge mclk);
    #1;
    cpu_req = 1'b1;
    cpu_wr = w;
    cpu_size = sz;
    cpu_addr = a;
    cpu_wdata = d;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (cpu_ack !== 1'b1 && n < 20);
    rd = cpu_rdata;
    chk(32'(n < 20), 32'h1, "access answered");
    @(posedge mclk);
    #1 cpu_req = 1'b0;
  endtask
  task automatic wr(input logic [1:0] sz, input logic [6:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, sz, a, d, x);
  endtask
  task automatic rdc(input logic [1:0] sz, input logic [6:0] a, input logic [31:0] e, input string what);
    logic [31:0] x;
    acc(1'b0, sz, a, 32'h0, x);
    chk(x, e, what);
  endtask
  task automatic wait_pins(input logic [3:0] e, input logic [3:0] p);
    int n;
    n = 0;
    while (peripheral_select_pattern !== e && n < 3000) begin
      if (peripheral_select_pattern !== p) chk(32'(peripheral_select_pattern), 32'(p), "pins left pattern");
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(peripheral_select_pattern), 32'(e), "select pins");
  endtask
  task automatic wait_flag(input logic hold);
    int n;
    n = 0;
    while (queue_finished_flag !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
      if (hold && completed_entry_pointer === 4'h4) chk(32'(peripheral_select_pattern), 32'h5, "held pins");
    end
    chk(32'(queue_finished_flag), 32'h1, "finished flag");
  endtask
  function automatic logic [15:0] exp_rx(input logic [3:0] p, input int n);
    return ({4{p}} ^ 16'h3c96) >> (16 - n);
  endfunction
  // ********************************
  // Tests
  // ********************************
  initial begin
    #100000;
    fails++;
    $display("wrong value at %0t: run timed out", $time);
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(32'(completed_entry_pointer), 32'h0, "pointer reset");
    @(posedge mclk);
    #1 pin_assignment_register = 4'hf;
    @(posedge mclk);
    #1 port_data_register = 4'hf;
    @(posedge mclk);
    #1 pin_direction_register = 4'hf;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(peripheral_select_pattern), 32'hf, "idle pins");
    chk(32'(peripheral_select_oe), 32'hf, "pin enables");
    $display("test pins done");
    wr(spi_queue_pkg::SZ_WORD, 7'h24, 32'h0000a5c3);
    wr(spi_queue_pkg::SZ_BYTE, 7'h25, 32'h0000003c);
    rdc(spi_queue_pkg::SZ_WORD, 7'h24, 32'h0000a53c, "byte into word");
    wr(spi_queue_pkg::SZ_LONG, 7'h26, 32'h0f0e0d0c);
    rdc(spi_queue_pkg::SZ_WORD, 7'h28, 32'h00000d0c, "long low half");
    wr(spi_queue_pkg::SZ_WORD, 7'h27, 32'h00001234);
    rdc(spi_queue_pkg::SZ_LONG, 7'h26, 32'h0f12340c, "odd word");
    wr(spi_queue_pkg::SZ_BYTE, 7'h52, 32'h00000077);
    rdc(spi_queue_pkg::SZ_BYTE, 7'h52, 32'h00000000, "unmapped");
    wr(spi_queue_pkg::SZ_WORD, 7'h26, 32'h00000abc);
    wr(spi_queue_pkg::SZ_BYTE, 7'h42, 32'h00000085);
    wr(spi_queue_pkg::SZ_BYTE, 7'h43, 32'h0000007a);
    rdc(spi_queue_pkg::SZ_BYTE, 7'h43, 32'h0000007a, "command byte");
    $display("test memory done");
    queue_start_pointer = 4'h2;
    queue_end_pointer = 4'h3;
    global_bit_count = 4'hc;
    select_to_clock_delay_length = 7'h10;
    after_transfer_delay_length = 8'h01;
    master_select = 1'b1;
    engine_enable = 1'b1;
    rdc(spi_queue_pkg::SZ_LONG, 7'h24, 32'ha53c0abc, "tx while running");
    wait_pins(4'h5, 4'hf);
    wait_pins(4'ha, 4'h5);
    wait_pins(4'hf, 4'ha);
    wait_flag(1'b0);
    chk(32'(completed_entry_pointer), 32'h3, "completed pointer");
    chk(32'(rx_word[11:0]), 32'h00000abc, "peer received");
    rdc(spi_queue_pkg::SZ_LONG, 7'h04, {exp_rx(4'h5, 8), exp_rx(4'ha, 12)}, "rx words");
    rdc(spi_queue_pkg::SZ_WORD, 7'h26, 32'h00000abc, "tx kept");
    rdc(spi_queue_pkg::SZ_BYTE, 7'h42, 32'h00000085, "command kept");
    engine_enable = 1'b0;
    finished_clear = 1'b1;
    @(posedge mclk);
    #1 finished_clear = 1'b0;
    chk(32'(queue_finished_flag), 32'h0, "flag cleared");
    $display("test switching queue done");
    wr(spi_queue_pkg::SZ_BYTE, 7'h44, 32'h00000085);
    wr(spi_queue_pkg::SZ_BYTE, 7'h45, 32'h00000085);
    queue_start_pointer = 4'h4;
    queue_end_pointer = 4'h5;
    engine_enable = 1'b1;
    wait_flag(1'b1);
    chk(32'(completed_entry_pointer), 32'h5, "completed pointer");
    rdc(spi_queue_pkg::SZ_WORD, 7'h08, 32'(exp_rx(4'h5, 8)), "rx entry four");
    engine_enable = 1'b0;
    wait_pins(4'hf, 4'h5);
    $display("test holding queue done");
    end_of_test;
  end
endmodule
